// ===== verilog/bmt_timer.sv
// debug break timer and execution time measurement unit, apb slave
// Operation
// R1: four break modes: off, timeout, run, delay
// R2: disabled mode never counts nor breaks
// R3: timeout: break on breakpoint before limit
// R4: run mode: count from start, break at limit
// R5: delay mode: count from hit, break at limit
// R6: break count source: 10 us time base
// R7: host selects one of eight interval pairs
// R8: run start to program stop
// R9: run start to measure end point
// R10: run start to trace event
// R11: trace event to measure end point
// R12: trace event to program stop
// R13: measure start point to end point
// R14: measure start point to trace event
// R15: measure start point to program stop
// R16: measure count source: 100 ns time base
// R17: measure count source: target machine cycles
// R18: hold result until read; saturate, no wrap; here a start event in hold opens a new interval and clears the unread result
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "bmt_defines.svh"

module bmt_timer
    import bmt_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    // clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_B_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // emulator execution events, asynchronous levels
    input  wire logic        RUN_START_I,
    input  wire logic        PROG_STOP_I,
    input  wire logic        BKPT_HIT_I,
    input  wire logic        TRACE_EVT_I,
    input  wire logic        MEAS_START_PT_I,
    input  wire logic        MEAS_END_PT_I,
    input  wire logic        MACH_CYC_I,
    // break request and interrupt
    output logic             BREAK_REQ_O,
    output logic             IRQ_O
);

    localparam logic [11:0] BRK_DIV_LAST  = 12'(`BMT_BRK_TB_CYC - 1);
    localparam logic [4:0]  MEAS_DIV_LAST = 5'(`BMT_MEAS_TB_CYC - 1);

    // pick one of three event pulses by a 2-bit selector
    function automatic logic evt_pick(input logic [1:0] sel,
                                      input logic a,
                                      input logic b,
                                      input logic c);
        case (sel)
            2'd0:    evt_pick = a;
            2'd1:    evt_pick = b;
            default: evt_pick = c;
        endcase
    endfunction : evt_pick

    logic [6:0]       ev_s1_r;
    logic [6:0]       ev_s2_r;
    logic [6:0]       ev_s3_r;
    logic [6:0]       ev;
    logic [7:0]       ctrl_r;
    logic [CNT_W-1:0] limit_r;
    logic [CNT_W-1:0] brk_cnt_r;
    logic [11:0]      brk_pre_r;
    logic [CNT_W-1:0] meas_cnt_r;
    logic [4:0]       meas_pre_r;
    logic             meas_ovf_r;
    logic [2:0]       irq_stat_r;
    logic [2:0]       irq_mask_r;
    logic [2:0]       irq_set;
    logic [31:0]      rdata_nxt;
    logic             rd_err_nxt;
    logic             pready_r;
    logic             apb_acc;
    logic             wr_ctrl;
    logic             wr_limit;
    logic             wr_istat;
    logic             wr_imask;
    logic             rd_meas;
    logic             brk_tick;
    logic             meas_tick;
    logic             start_ev;
    logic             stop_ev;
    logic             break_req_r;
    logic             irq_r;
    logic [31:0]      prdata_r;
    logic             pslverr_r;
    logic [1:0]       start_sel;
    logic [1:0]       stop_sel;
    bmt_mode_e        mode;
    bmt_brk_state_e   brk_state_r;
    bmt_meas_state_e  meas_state_r;

    // events cross in through two flops; a third flop finds rising edges
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
        begin
            ev_s1_r <= 7'h00;
            ev_s2_r <= 7'h00;
            ev_s3_r <= 7'h00;
        end
        else
        begin
            ev_s1_r <= {MACH_CYC_I, MEAS_END_PT_I, MEAS_START_PT_I,
                        TRACE_EVT_I, BKPT_HIT_I, PROG_STOP_I, RUN_START_I};
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end

    assign ev = ev_s2_r & ~ev_s3_r;

    // apb strobes; every access finishes in its first access cycle
    assign apb_acc  = PSEL_I & PENABLE_I & pready_r;
    assign wr_ctrl  = apb_acc & PWRITE_I & (PADDR_I == `BMT_CTRL_OFS);
    assign wr_limit = apb_acc & PWRITE_I & (PADDR_I == `BMT_BRK_LIMIT_OFS);
    assign wr_istat = apb_acc & PWRITE_I & (PADDR_I == `BMT_IRQ_STAT_OFS);
    assign wr_imask = apb_acc & PWRITE_I & (PADDR_I == `BMT_IRQ_MASK_OFS);
    assign rd_meas  = apb_acc & ~PWRITE_I & (PADDR_I == `BMT_MEAS_COUNT_OFS);

    // read mux; unmapped offsets answer zero with an error
    always_comb
    begin
        rdata_nxt  = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        case (PADDR_I)
            `BMT_CTRL_OFS:       rdata_nxt = {24'h00_0000, ctrl_r};
            `BMT_BRK_LIMIT_OFS:  rdata_nxt = 32'(limit_r);
            `BMT_BRK_COUNT_OFS:  rdata_nxt = 32'(brk_cnt_r);
            `BMT_MEAS_COUNT_OFS: rdata_nxt = 32'(meas_cnt_r);
            `BMT_STATUS_OFS:     rdata_nxt = {28'h000_0000,
                                     brk_state_r == BMT_BRK_RUN,
                                     meas_ovf_r,
                                     meas_state_r == BMT_MEAS_HOLD,
                                     meas_state_r == BMT_MEAS_COUNT};
            `BMT_IRQ_STAT_OFS:   rdata_nxt = {29'h0000_0000, irq_stat_r};
            `BMT_IRQ_MASK_OFS:   rdata_nxt = {29'h0000_0000, irq_mask_r};
            default:             rd_err_nxt = 1'b1;
        endcase
    end

    // ready, data and error are set up during the setup cycle
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= PSEL_I & ~PENABLE_I;
            prdata_r  <= PWRITE_I ? 32'h0000_0000 : rdata_nxt;
            pslverr_r <= PSEL_I & ~PENABLE_I & rd_err_nxt;
        end
    end

    // software registers
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
        begin
            ctrl_r     <= `BMT_CTRL_RST;
            limit_r    <= CNT_W'(`BMT_LIMIT_RST);
            irq_mask_r <= 3'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= PWDATA_I[7:0];
            if (wr_limit)
                limit_r <= PWDATA_I[CNT_W-1:0];
            if (wr_imask)
                irq_mask_r <= PWDATA_I[2:0];
        end
    end

    assign mode = bmt_mode_e'(ctrl_r[`BMT_CTRL_MODE_LSB +: 2]); // see R1

    // break time base: 10 us prescaler or machine cycles
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
            brk_pre_r <= 12'h000;
        else if (brk_state_r != BMT_BRK_RUN || brk_pre_r == BRK_DIV_LAST)
            brk_pre_r <= 12'h000; // see R6
        else
            brk_pre_r <= brk_pre_r + 12'h001;
    end

    assign brk_tick = ctrl_r[`BMT_CTRL_BSRC_BIT] ? ev[`BMT_EV_MCYC]
                    : (brk_pre_r == BRK_DIV_LAST); // see R6

    // break state machine; a program stop returns it to idle from run or expired
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
        begin
            brk_state_r <= BMT_BRK_IDLE;
            brk_cnt_r   <= '0;
            break_req_r <= 1'b0;
        end
        else
        begin
            break_req_r <= 1'b0;
            if (mode == BMT_TIMER_DISABLED_MODE)
            begin
                brk_state_r <= BMT_BRK_IDLE; // see R2
            end
            else
            begin
                case (brk_state_r)
                    BMT_BRK_IDLE:
                    begin
                        // delay mode arms on a hit, others on run start
                        if ((mode == BMT_BREAK_AFTER_HIT_DELAY_MODE)
                            ? ev[`BMT_EV_BKPT] : ev[`BMT_EV_RUN])
                        begin
                            brk_state_r <= BMT_BRK_RUN; // see R4 see R5
                            brk_cnt_r   <= '0;
                        end
                    end
                    BMT_BRK_RUN:
                    begin
                        if (ev[`BMT_EV_STOP])
                            brk_state_r <= BMT_BRK_IDLE;
                        else if (mode == BMT_BREAK_ON_TIMEOUT_MODE
                                 && ev[`BMT_EV_BKPT]
                                 && brk_cnt_r < limit_r)
                        begin
                            break_req_r <= 1'b1; // see R3
                            brk_state_r <= BMT_BRK_EXPIRED;
                        end
                        else if (brk_cnt_r >= limit_r)
                        begin
                            // timeout mode simply lapses at the limit
                            break_req_r <= mode != BMT_BREAK_ON_TIMEOUT_MODE;
                            brk_state_r <= BMT_BRK_EXPIRED; // see R4 see R5
                        end
                        else if (brk_tick)
                            brk_cnt_r <= brk_cnt_r + CNT_W'(1);
                    end
                    BMT_BRK_EXPIRED:
                    begin
                        if (ev[`BMT_EV_STOP] || ev[`BMT_EV_RUN])
                            brk_state_r <= BMT_BRK_IDLE;
                    end
                    default: brk_state_r <= BMT_BRK_IDLE;
                endcase
            end
        end
    end

    // interval pair decode
    always_comb
    begin
        case (ctrl_r[`BMT_CTRL_PAIR_LSB +: 3]) // see R7
            3'd0:    begin start_sel = 2'd0; stop_sel = 2'd0; end // see R8
            3'd1:    begin start_sel = 2'd0; stop_sel = 2'd1; end // see R9
            3'd2:    begin start_sel = 2'd0; stop_sel = 2'd2; end // see R10
            3'd3:    begin start_sel = 2'd1; stop_sel = 2'd1; end // see R11
            3'd4:    begin start_sel = 2'd1; stop_sel = 2'd0; end // see R12
            3'd5:    begin start_sel = 2'd2; stop_sel = 2'd1; end // see R13
            3'd6:    begin start_sel = 2'd2; stop_sel = 2'd2; end // see R14
            default: begin start_sel = 2'd2; stop_sel = 2'd0; end // see R15
        endcase
    end

    assign start_ev = evt_pick(start_sel, ev[`BMT_EV_RUN],
                               ev[`BMT_EV_TRACE], ev[`BMT_EV_MSTART]);
    assign stop_ev  = evt_pick(stop_sel, ev[`BMT_EV_STOP],
                               ev[`BMT_EV_MEND], ev[`BMT_EV_TRACE]);

    // measure time base: 100 ns prescaler or machine cycles
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
            meas_pre_r <= 5'h00;
        else if (meas_state_r != BMT_MEAS_COUNT || meas_pre_r == MEAS_DIV_LAST)
            meas_pre_r <= 5'h00; // see R16
        else
            meas_pre_r <= meas_pre_r + 5'h01;
    end

    assign meas_tick = ctrl_r[`BMT_CTRL_MSRC_BIT] ? ev[`BMT_EV_MCYC] // see R17
                     : (meas_pre_r == MEAS_DIV_LAST); // see R16

    // measurement state machine; stop wins over a same-cycle start only while counting
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
        begin
            meas_state_r <= BMT_MEAS_WAIT;
            meas_cnt_r   <= '0;
            meas_ovf_r   <= 1'b0;
        end
        else
        begin
            case (meas_state_r)
                BMT_MEAS_COUNT:
                begin
                    if (stop_ev)
                        meas_state_r <= BMT_MEAS_HOLD; // see R8 see R13
                    else if (meas_tick && &meas_cnt_r)
                        meas_ovf_r <= 1'b1; // see R18
                    else if (meas_tick)
                        meas_cnt_r <= meas_cnt_r + CNT_W'(1);
                end
                BMT_MEAS_HOLD:
                begin
                    // result stays until read or a new interval opens
                    if (start_ev)
                    begin
                        meas_state_r <= BMT_MEAS_COUNT; // see R18
                        meas_cnt_r   <= '0;
                        meas_ovf_r   <= 1'b0;
                    end
                    else if (rd_meas)
                        meas_state_r <= BMT_MEAS_WAIT;
                end
                default:
                begin
                    if (start_ev)
                    begin
                        meas_state_r <= BMT_MEAS_COUNT; // see R9 see R14
                        meas_cnt_r   <= '0;
                        meas_ovf_r   <= 1'b0;
                    end
                end
            endcase
        end
    end

    // sticky interrupt flags; a new event beats a same-cycle clear
    assign irq_set = {meas_state_r == BMT_MEAS_COUNT && meas_tick
                          && &meas_cnt_r && !meas_ovf_r && !stop_ev,
                      meas_state_r == BMT_MEAS_COUNT && stop_ev,
                      break_req_r};

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_B_I)
        begin
            irq_stat_r <= 3'h0;
            irq_r      <= 1'b0;
        end
        else
        begin
            irq_stat_r <= irq_set
                        | (irq_stat_r & ~(wr_istat ? PWDATA_I[2:0] : 3'h0));
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign PRDATA_O    = prdata_r;
    assign PREADY_O    = pready_r;
    assign PSLVERR_O   = pslverr_r;
    assign BREAK_REQ_O = break_req_r;
    assign IRQ_O       = irq_r;

    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);

    property p_off_quiet;
        break_req_r |-> $past(mode) != BMT_TIMER_DISABLED_MODE;
    endproperty
    a_off_quiet: assert property (p_off_quiet) // see R2
        else $error("break raised while timer disabled");

    property p_timeout_hit;
        (brk_state_r == BMT_BRK_RUN && mode == BMT_BREAK_ON_TIMEOUT_MODE
         && ev[`BMT_EV_BKPT] && !ev[`BMT_EV_STOP] && brk_cnt_r < limit_r
         && !wr_ctrl) |=> break_req_r;
    endproperty
    a_timeout_hit: assert property (p_timeout_hit) // see R3
        else $error("timeout mode missed breakpoint break");

    property p_run_limit;
        (brk_state_r == BMT_BRK_RUN && mode == BMT_BREAK_AFTER_RUN_TIME_MODE
         && !ev[`BMT_EV_STOP] && brk_cnt_r >= limit_r && !wr_ctrl)
        |=> break_req_r ##1 !break_req_r;
    endproperty
    a_run_limit: assert property (p_run_limit) // see R4
        else $error("run time break not a single pulse at limit");

    property p_delay_arm;
        (brk_state_r == BMT_BRK_IDLE && mode == BMT_BREAK_AFTER_HIT_DELAY_MODE
         && ev[`BMT_EV_BKPT] && !wr_ctrl)
        |=> brk_state_r == BMT_BRK_RUN && brk_cnt_r == '0;
    endproperty
    a_delay_arm: assert property (p_delay_arm) // see R5
        else $error("delay mode did not arm on breakpoint");

    property p_brk_base;
        (brk_tick && !ctrl_r[`BMT_CTRL_BSRC_BIT])
        |-> $past(brk_pre_r) == BRK_DIV_LAST - 12'h001;
    endproperty
    a_brk_base: assert property (p_brk_base) // see R6
        else $error("break time base period wrong");

    property p_meas_base;
        (meas_tick && !ctrl_r[`BMT_CTRL_MSRC_BIT]
         && meas_state_r == BMT_MEAS_COUNT
         && $past(meas_state_r) == meas_state_r)
        |-> $past(meas_pre_r, 1) == MEAS_DIV_LAST - 5'h01;
    endproperty
    a_meas_base: assert property (p_meas_base) // see R16
        else $error("measure time base period wrong");

    property p_meas_cycle;
        (meas_state_r == BMT_MEAS_COUNT && ctrl_r[`BMT_CTRL_MSRC_BIT]
         && ev[`BMT_EV_MCYC] && !stop_ev && !(&meas_cnt_r))
        |=> meas_cnt_r == $past(meas_cnt_r) + CNT_W'(1);
    endproperty
    a_meas_cycle: assert property (p_meas_cycle) // see R17
        else $error("machine cycle not counted");

    property p_meas_stop;
        (meas_state_r == BMT_MEAS_COUNT && stop_ev)
        |=> meas_state_r == BMT_MEAS_HOLD && irq_stat_r[`BMT_IRQ_MDONE];
    endproperty
    a_meas_stop: assert property (p_meas_stop) // see R8
        else $error("stop event did not close interval");

    property p_meas_hold;
        (meas_state_r == BMT_MEAS_HOLD && !start_ev)
        |=> $stable(meas_cnt_r);
    endproperty
    a_meas_hold: assert property (p_meas_hold) // see R18
        else $error("held result changed");

    c_timeout_break: cover property (mode == BMT_BREAK_ON_TIMEOUT_MODE
                                     && break_req_r);
    c_delay_break: cover property (mode == BMT_BREAK_AFTER_HIT_DELAY_MODE
                                   && break_req_r);
    c_meas_done: cover property (meas_state_r == BMT_MEAS_COUNT
                                 ##[1:1000] meas_state_r == BMT_MEAS_HOLD);
    c_irq: cover property (irq_r);

endmodule : bmt_timer

// ===== shared/bmt_defines.svh
// register map, field positions, reset values and timing counts
`ifndef BMT_DEFINES_SVH
`define BMT_DEFINES_SVH

// register byte offsets
`define BMT_CTRL_OFS        8'h00
`define BMT_BRK_LIMIT_OFS   8'h04
`define BMT_BRK_COUNT_OFS   8'h08
`define BMT_MEAS_COUNT_OFS  8'h0c
`define BMT_STATUS_OFS      8'h10
`define BMT_IRQ_STAT_OFS    8'h14
`define BMT_IRQ_MASK_OFS    8'h18

// control register fields
`define BMT_CTRL_MODE_LSB   0
`define BMT_CTRL_BSRC_BIT   2
`define BMT_CTRL_PAIR_LSB   4
`define BMT_CTRL_MSRC_BIT   7
`define BMT_CTRL_RST        8'h00
`define BMT_LIMIT_RST       32'h0000_0000

// status and interrupt bits
`define BMT_ST_MEASURING    0
`define BMT_ST_HELD         1
`define BMT_ST_OVERFLOW     2
`define BMT_ST_BRK_RUN      3
`define BMT_IRQ_BREAK       0
`define BMT_IRQ_MDONE       1
`define BMT_IRQ_MOVF        2

// synchronised event inputs
`define BMT_EV_RUN          0
`define BMT_EV_STOP         1
`define BMT_EV_BKPT         2
`define BMT_EV_TRACE        3
`define BMT_EV_MSTART       4
`define BMT_EV_MEND         5
`define BMT_EV_MCYC         6

// time bases
`define BMT_CLK_MHZ         250
`define BMT_BRK_TB_NS       10000
`define BMT_BRK_TB_CYC      ((`BMT_BRK_TB_NS * `BMT_CLK_MHZ) / 1000)
`define BMT_MEAS_TB_NS      100
`define BMT_MEAS_TB_CYC     ((`BMT_MEAS_TB_NS * `BMT_CLK_MHZ) / 1000)

`endif

// ===== shared/bmt_pkg.sv
// types for the debug break and measure timer
package bmt_pkg;

    typedef enum logic [1:0]
    {
        BMT_TIMER_DISABLED_MODE    = 2'b00,
        BMT_BREAK_ON_TIMEOUT_MODE  = 2'b01,
        BMT_BREAK_AFTER_RUN_TIME_MODE = 2'b10,
        BMT_BREAK_AFTER_HIT_DELAY_MODE = 2'b11
    } bmt_mode_e;

    typedef enum logic [1:0]
    {
        BMT_BRK_IDLE    = 2'b00,
        BMT_BRK_RUN     = 2'b01,
        BMT_BRK_EXPIRED = 2'b10
    } bmt_brk_state_e;

    typedef enum logic [1:0]
    {
        BMT_MEAS_WAIT  = 2'b00,
        BMT_MEAS_COUNT = 2'b01,
        BMT_MEAS_HOLD  = 2'b10
    } bmt_meas_state_e;

endpackage : bmt_pkg

// ===== tb/bmt_target_model.sv
// target execution model: run, stop, breakpoint, trace, points, cycles
`timescale 1ns/1ns

module bmt_target_model
(
    // clock
    input  wire logic       clk_i,
    // one-clock event requests from the test sequence
    input  wire logic [6:0] fire_i,
    // event levels towards the timer
    output logic      [6:0] ev_o
);
    logic [6:0] fire_d_r;

    // each request shows as a level two clocks wide, as the target
    // drives it; requests are idle low, so reset release is no edge
    always_ff @(posedge clk_i)
    begin
        fire_d_r <= fire_i;
        ev_o     <= fire_i | fire_d_r;
    end
endmodule : bmt_target_model

// ===== tb/testbench.sv
// self-checking bench for the debug break and measure timer
`timescale 1ns/1ns
`include "bmt_defines.svh"

module testbench;
    logic        clk     = 1'b0;
    logic        rst_b   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  ev;
    logic [6:0]  fire    = 7'h00;
    logic        brk;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          errors  = 0;
    int          checks  = 0;
    int          brk_n   = 0;
    // start and stop events of the eight intervals, in pair order
    int          st_ev [8] = '{0, 0, 0, 3, 3, 4, 4, 4};
    int          sp_ev [8] = '{1, 5, 3, 5, 1, 5, 3, 1};

    // 250 MHz reference clock
    always #2 clk = ~clk;

    // narrow counters let a short run reach saturation
    bmt_timer #(.CNT_W(8)) dut
    (
        .REF_CLK_I       (clk),
        .RST_B_I         (rst_b),
        .PSEL_I          (psel),
        .PENABLE_I       (penable),
        .PWRITE_I        (pwrite),
        .PADDR_I         (paddr),
        .PWDATA_I        (pwdata),
        .PRDATA_O        (prdata),
        .PREADY_O        (pready),
        .PSLVERR_O       (pslverr),
        .RUN_START_I     (ev[0]),
        .PROG_STOP_I     (ev[1]),
        .BKPT_HIT_I      (ev[2]),
        .TRACE_EVT_I     (ev[3]),
        .MEAS_START_PT_I (ev[4]),
        .MEAS_END_PT_I   (ev[5]),
        .MACH_CYC_I      (ev[6]),
        .BREAK_REQ_O     (brk),
        .IRQ_O           (irq)
    );

    bmt_target_model tgt
    (
        .clk_i  (clk),
        .fire_i (fire),
        .ev_o   (ev)
    );

    // one event: one request clock, then time for sync and effect
    task automatic pulse(input int k);
        @(posedge clk);
        fire <= 7'h01 << k;
        @(posedge clk);
        fire <= 7'h00;
        repeat (7) @(posedge clk);
    endtask : pulse

    // n machine cycles of the target, each one rising edge
    task automatic mcyc(input int n);
        repeat (n) pulse(`BMT_EV_MCYC);
    endtask : mcyc

    // break pulses are one cycle wide, so count them edge by edge
    always @(posedge clk)
        if (brk === 1'b1)
            brk_n <= brk_n + 1;

    // one apb transfer; an idle edge after it keeps strobes clean
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // read a register and compare the word
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask : rchk

    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // watchdog: the whole sequence needs well under 20000 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        errors++;
        $display("BAD watchdog expected done seen timeout");
        summarize();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rchk("ctrl", `BMT_CTRL_OFS, 32'h0000_0000);
        rchk("limit", `BMT_BRK_LIMIT_OFS, 32'h0000_0000);
        rchk("mask", `BMT_IRQ_MASK_OFS, 32'h0000_0000);
        rchk("status", `BMT_STATUS_OFS, 32'h0000_0000);
        rchk("unmapped", 8'h1c, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, err});
        wr(`BMT_CTRL_OFS, 32'h0000_00f7);
        rchk("ctrl rw", `BMT_CTRL_OFS, 32'h0000_00f7);
        $display("test registers done");
        // disabled mode ignores run, cycles and breakpoints
        wr(`BMT_CTRL_OFS, 32'h0000_0004);
        wr(`BMT_BRK_LIMIT_OFS, 32'h0000_0001);
        pulse(`BMT_EV_RUN);
        mcyc(4);
        pulse(`BMT_EV_BKPT);
        chk("off breaks", 32'h0, brk_n);
        rchk("off count", `BMT_BRK_COUNT_OFS, 32'h0);
        pulse(`BMT_EV_STOP);
        // that stop closed a run-to-stop interval; drop its flag
        wr(`BMT_IRQ_STAT_OFS, 32'h0000_0007);
        $display("test disabled done");
        // run mode on machine cycles, limit three, interrupt unmasked
        wr(`BMT_CTRL_OFS, 32'h0000_0006);
        wr(`BMT_BRK_LIMIT_OFS, 32'h0000_0003);
        wr(`BMT_IRQ_MASK_OFS, 32'h0000_0001);
        pulse(`BMT_EV_RUN);
        mcyc(2);
        chk("run early", 32'h0, brk_n);
        mcyc(1);
        chk("run break", 32'h1, brk_n);
        chk("irq on", 32'h1, {31'h0, irq});
        rchk("irq stat", `BMT_IRQ_STAT_OFS, 32'h0000_0001);
        wr(`BMT_IRQ_STAT_OFS, 32'h0000_0001);
        @(posedge clk);
        chk("irq off", 32'h0, {31'h0, irq});
        pulse(`BMT_EV_STOP);
        $display("test run time done");
        // hit-delay mode: only the breakpoint arms, interrupt masked
        wr(`BMT_CTRL_OFS, 32'h0000_0007);
        wr(`BMT_BRK_LIMIT_OFS, 32'h0000_0002);
        wr(`BMT_IRQ_MASK_OFS, 32'h0000_0000);
        pulse(`BMT_EV_RUN);
        mcyc(3);
        chk("delay unarmed", 32'h1, brk_n);
        pulse(`BMT_EV_BKPT);
        mcyc(2);
        chk("delay break", 32'h2, brk_n);
        chk("masked irq", 32'h0, {31'h0, irq});
        pulse(`BMT_EV_STOP);
        $display("test hit delay done");
        // timeout: breakpoint inside the limit breaks, past it does not
        wr(`BMT_CTRL_OFS, 32'h0000_0005);
        wr(`BMT_BRK_LIMIT_OFS, 32'h0000_0005);
        pulse(`BMT_EV_RUN);
        mcyc(2);
        pulse(`BMT_EV_BKPT);
        chk("timeout hit", 32'h3, brk_n);
        // a stop returns the lapsed timer to idle so the run rearms it
        pulse(`BMT_EV_STOP);
        pulse(`BMT_EV_RUN);
        mcyc(6);
        pulse(`BMT_EV_BKPT);
        chk("timeout late", 32'h3, brk_n);
        pulse(`BMT_EV_STOP);
        $display("test timeout done");
        // 10 us base: limit two needs about 5000 cycles
        wr(`BMT_CTRL_OFS, 32'h0000_0002);
        wr(`BMT_BRK_LIMIT_OFS, 32'h0000_0002);
        pulse(`BMT_EV_RUN);
        repeat (2400) @(posedge clk);
        chk("base early", 32'h3, brk_n);
        repeat (2700) @(posedge clk);
        chk("base break", 32'h4, brk_n);
        pulse(`BMT_EV_STOP);
        wr(`BMT_IRQ_STAT_OFS, 32'h0000_0007);
        $display("test break base done");
        // every interval on machine cycles; cycles after stop are held
        for (int p = 0; p < 8; p++)
        begin
            wr(`BMT_CTRL_OFS, 32'h0000_0080 | (p << 4));
            pulse(st_ev[p]);
            mcyc(3);
            rchk("open", `BMT_STATUS_OFS, 32'h0000_0001);
            pulse(sp_ev[p]);
            mcyc(2);
            rchk("held", `BMT_STATUS_OFS, 32'h0000_0002);
            rchk("interval", `BMT_MEAS_COUNT_OFS, 32'h3);
            rchk("done irq", `BMT_IRQ_STAT_OFS, 32'h0000_0002);
            wr(`BMT_IRQ_STAT_OFS, 32'h0000_0002);
        end
        $display("test intervals done");
        // 100 ns base over about 250 cycles gives ten counts
        wr(`BMT_CTRL_OFS, 32'h0000_0000);
        pulse(`BMT_EV_RUN);
        repeat (244) @(posedge clk);
        pulse(`BMT_EV_STOP);
        apb(1'b0, `BMT_MEAS_COUNT_OFS, 32'h0000_0000);
        chk("base count", 32'h1, {31'h0, rd inside {[32'h9:32'hb]}});
        $display("test measure base done");
        // the narrow counter saturates on the 100 ns base and flags it
        pulse(`BMT_EV_RUN);
        repeat (6500) @(posedge clk);
        rchk("ovf status", `BMT_STATUS_OFS, 32'h0000_0005);
        rchk("ovf count", `BMT_MEAS_COUNT_OFS, 32'h0000_00ff);
        rchk("ovf irq", `BMT_IRQ_STAT_OFS, 32'h0000_0006);
        $display("test overflow done");
        summarize();
    end
endmodule : testbench
